// ===== rtl/sync_serial_pkg.sv
package sync_serial_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_FLAGS = 8'h10;
  localparam logic [7:0] IDX_ENABLES = 8'h11;
  localparam logic [7:0] IDX_CTRL = 8'h12;
  localparam logic [7:0] IDX_BUFFER = 8'h13;
  localparam logic [7:0] IDX_STATUS = 8'h14;
  localparam logic [9:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
  localparam logic [9:0] ADDR_ENABLES = {IDX_ENABLES, 2'b00};
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_BUFFER = {IDX_BUFFER, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_RST = 8'h02;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] IMPL_MASK = 8'hef;
  localparam int FLAG_SERIAL_BIT = 7;
  localparam int FLAG_COLL_BIT = 6;
  localparam int UNIMPL_BIT = 4;
  localparam logic [7:0] FLAG_SERIAL_MASK = 8'h80;
  localparam logic [7:0] FLAG_COLL_MASK = 8'h40;
  localparam int STAT_WRITE_COLLISION_FLAG_BIT = 7;
  localparam logic [7:0] STAT_WRITE_COLLISION_FLAG_MASK = 8'h80;
  localparam logic [7:0] STAT_BUSY_MASK = 8'h04;
  localparam logic [7:0] STAT_BF_MASK = 8'h01;
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [3:0] TX_LAST_DATA = 4'h7;
  localparam logic [3:0] TX_ACK_SLOT = 4'h8;
  localparam logic [3:0] RX_LAST_BIT = 4'h7;

  // ----------------------------------------------------------------
  // Timing: one quarter of a serial bit
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_QUARTER_NS = 2500;
  localparam int QUARTER_CYCLES = (T_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic general_call_irq_enable;
    logic ack_received_status;
    logic ack_value_bit;
    logic ack_sequence_go;
    logic receive_go;
    logic stop_go;
    logic restart_go;
    logic start_go;
  } ctrl_t;

  typedef enum {ST_IDLE, ST_START, ST_RESTART, ST_STOP, ST_TX, ST_RX, ST_ACK} seq_state_t;

endpackage : sync_serial_pkg

// ===== rtl/bit_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ------------------------------------------------------------------
module bit_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage; idle bus level is high
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      meta_r <= '1;
      dout <= '1;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule : bit_sync
`default_nettype wire

// ===== rtl/tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Quarter-bit tick generator, restarts whenever run drops
// ------------------------------------------------------------------
module tick_gen #(
  parameter int COUNT = 25
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic run,
  output logic tick
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt_r;

  assign tick = run & (cnt_r == LAST);

  // Count while running, wrap on the tick
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !run || tick)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

endmodule : tick_gen
`default_nettype wire

// ===== rtl/sync_serial_master_control.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Serial port master control with APB register access
// ------------------------------------------------------------------
module sync_serial_master_control #(
  parameter int QUARTER_CYCLES = sync_serial_pkg::QUARTER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sync_serial_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  sync_serial_pkg::seq_state_t state_r, state_nxt;
  sync_serial_pkg::ctrl_t ctrl_r, ctrl_nxt, wctrl;
  logic [1:0] qph_r, qph_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [7:0] shift_r, buffer_r, flags_r, enables_r, rd_byte, status_w, flag_set;
  logic [31:0] prdata_r;
  logic bf_r, write_collision_flag_r, tx_pend_r, scl_low_r, sda_low_r, scl_low_nxt, sda_low_nxt;
  logic scl_s, sda_s, qtick, stretch;

  // ----------------------------------------------------------------
  // Pin synchronisers and quarter-bit timing
  // ----------------------------------------------------------------
  bit_sync #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .din({scl_in, sda_in}),
    .dout({scl_s, sda_s})
  );

  tick_gen #(.COUNT(QUARTER_CYCLES)) u_tick (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run((state_r != sync_serial_pkg::ST_IDLE) & ~stretch),
    .tick(qtick)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire access = psel & penable;
  wire hit_flags = paddr == sync_serial_pkg::ADDR_FLAGS;
  wire hit_enables = paddr == sync_serial_pkg::ADDR_ENABLES;
  wire hit_ctrl = paddr == sync_serial_pkg::ADDR_CTRL;
  wire hit_buffer = paddr == sync_serial_pkg::ADDR_BUFFER;
  wire hit_status = paddr == sync_serial_pkg::ADDR_STATUS;
  wire mapped = hit_flags | hit_enables | hit_ctrl | hit_buffer | hit_status;
  wire wr = access & pwrite & mapped;
  wire rd = access & ~pwrite & mapped;
  wire ctrl_wr = wr & hit_ctrl;
  wire buf_wr = wr & hit_buffer;
  wire buf_rd = rd & hit_buffer;
  assign wctrl = sync_serial_pkg::ctrl_t'(pwdata[7:0]);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // Sequencer state decode
  // ----------------------------------------------------------------
  wire idle = state_r == sync_serial_pkg::ST_IDLE;
  wire busy = ~idle;
  wire in_start = state_r == sync_serial_pkg::ST_START;
  wire in_restart = state_r == sync_serial_pkg::ST_RESTART;
  wire in_stop = state_r == sync_serial_pkg::ST_STOP;
  wire in_tx = state_r == sync_serial_pkg::ST_TX;
  wire in_rx = state_r == sync_serial_pkg::ST_RX;
  wire in_ack = state_r == sync_serial_pkg::ST_ACK;
  wire go_any = ctrl_r.start_go | ctrl_r.restart_go | ctrl_r.stop_go | ctrl_r.receive_go
              | ctrl_r.ack_sequence_go;
  wire port_idle = idle & ~go_any & ~tx_pend_r;
  wire launch_tx = idle & ~go_any & tx_pend_r;
  wire seq_end = qtick & (qph_r == 2'd3);
  wire sample = qtick & (qph_r == 2'd2);
  wire tx_data = in_tx & (bitcnt_r <= sync_serial_pkg::TX_LAST_DATA);
  wire ack_sample = sample & in_tx & (bitcnt_r == sync_serial_pkg::TX_ACK_SLOT);
  wire collide = sample & tx_data & ~sda_low_r & ~sda_s;
  wire tx_byte_out = seq_end & in_tx & (bitcnt_r == sync_serial_pkg::TX_LAST_DATA);
  wire tx_done = seq_end & in_tx & (bitcnt_r == sync_serial_pkg::TX_ACK_SLOT);
  wire rx_done = seq_end & in_rx & (bitcnt_r == sync_serial_pkg::RX_LAST_BIT);
  wire cond_done = seq_end & (in_start | in_restart | in_stop | in_ack);
  wire gcall_hit = rx_done & ctrl_r.general_call_irq_enable
                 & (shift_r == sync_serial_pkg::GENERAL_CALL_ADDR);
  wire serial_evt = tx_done | rx_done | cond_done | gcall_hit;
  wire buf_load = buf_wr & port_idle;
  wire write_collision_flag_set = buf_wr & (in_tx | tx_pend_r);
  wire bit_low = in_ack ? ~ctrl_r.ack_value_bit : (tx_data & ~shift_r[7]);

  // Slave holding SCL low after release stops the bit timer, which restarts its count from zero
  assign stretch = (qph_r == 2'd2) & ~scl_low_r & ~scl_s;
  assign qph_nxt = idle ? 2'd0 : (qtick ? 2'(qph_r + 2'd1) : qph_r);
  assign bitcnt_nxt = idle ? 4'd0 : (seq_end ? 4'(bitcnt_r + 4'd1) : bitcnt_r);

  // Next sequence; go bits taken in fixed priority from idle
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      sync_serial_pkg::ST_IDLE:
        if (ctrl_r.start_go)
          state_nxt = sync_serial_pkg::ST_START;
        else if (ctrl_r.restart_go)
          state_nxt = sync_serial_pkg::ST_RESTART;
        else if (ctrl_r.stop_go)
          state_nxt = sync_serial_pkg::ST_STOP;
        else if (ctrl_r.receive_go)
          state_nxt = sync_serial_pkg::ST_RX;
        else if (ctrl_r.ack_sequence_go)
          state_nxt = sync_serial_pkg::ST_ACK;
        else if (tx_pend_r)
          state_nxt = sync_serial_pkg::ST_TX;
      sync_serial_pkg::ST_START, sync_serial_pkg::ST_RESTART, sync_serial_pkg::ST_STOP,
      sync_serial_pkg::ST_ACK:
        if (seq_end)
          state_nxt = sync_serial_pkg::ST_IDLE;
      sync_serial_pkg::ST_TX:
        if (tx_done || collide)
          state_nxt = sync_serial_pkg::ST_IDLE;
      sync_serial_pkg::ST_RX:
        if (rx_done)
          state_nxt = sync_serial_pkg::ST_IDLE;
    endcase
  end

  // Line actions per quarter: 0 set data, 1 release clock, 2 sample, 3 clock low
  always_comb
  begin
    scl_low_nxt = scl_low_r;
    sda_low_nxt = sda_low_r;
    if (collide)
    begin
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
    end
    else if (qtick)
    begin
      unique case (state_r)
        sync_serial_pkg::ST_IDLE:
          sda_low_nxt = sda_low_r;
        sync_serial_pkg::ST_START:
        begin
          scl_low_nxt = (qph_r == 2'd3) ? 1'b1 : ((qph_r == 2'd0) ? 1'b0 : scl_low_r);
          sda_low_nxt = (qph_r == 2'd1) ? 1'b1 : ((qph_r == 2'd0) ? 1'b0 : sda_low_r);
        end
        sync_serial_pkg::ST_RESTART:
        begin
          scl_low_nxt = (qph_r == 2'd1) ? 1'b0 : ((qph_r == 2'd3) ? 1'b1 : scl_low_r);
          sda_low_nxt = (qph_r == 2'd0) ? 1'b0 : ((qph_r == 2'd2) ? 1'b1 : sda_low_r);
        end
        sync_serial_pkg::ST_STOP:
        begin
          scl_low_nxt = (qph_r == 2'd1) ? 1'b0 : scl_low_r;
          sda_low_nxt = (qph_r == 2'd0) ? 1'b1 : ((qph_r == 2'd2) ? 1'b0 : sda_low_r);
        end
        sync_serial_pkg::ST_TX, sync_serial_pkg::ST_RX, sync_serial_pkg::ST_ACK:
        begin
          scl_low_nxt = (qph_r == 2'd1) ? 1'b0 : ((qph_r == 2'd3) ? 1'b1 : scl_low_r);
          sda_low_nxt = (qph_r == 2'd0) ? bit_low : sda_low_r;
        end
      endcase
    end
  end

  // Control register: software fields, guarded go bits, hardware clears
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr)
    begin
      ctrl_nxt.general_call_irq_enable = wctrl.general_call_irq_enable;
      ctrl_nxt.ack_value_bit = wctrl.ack_value_bit;
    end
    if (ctrl_wr && port_idle)
    begin
      ctrl_nxt.ack_sequence_go = wctrl.ack_sequence_go;
      ctrl_nxt.receive_go = wctrl.receive_go;
      ctrl_nxt.stop_go = wctrl.stop_go;
      ctrl_nxt.restart_go = wctrl.restart_go;
      ctrl_nxt.start_go = wctrl.start_go;
    end
    if (seq_end && in_start)
      ctrl_nxt.start_go = 1'b0;
    if (seq_end && in_restart)
      ctrl_nxt.restart_go = 1'b0;
    if (seq_end && in_stop)
      ctrl_nxt.stop_go = 1'b0;
    if (seq_end && in_ack)
      ctrl_nxt.ack_sequence_go = 1'b0;
    if (rx_done)
      ctrl_nxt.receive_go = 1'b0;
    if (ack_sample)
      ctrl_nxt.ack_received_status = sda_s;
  end

  // ----------------------------------------------------------------
  // Read data; shift register is never on the map
  // ----------------------------------------------------------------
  assign status_w = (write_collision_flag_r ? sync_serial_pkg::STAT_WRITE_COLLISION_FLAG_MASK : 8'h00)
                  | (busy ? sync_serial_pkg::STAT_BUSY_MASK : 8'h00)
                  | (bf_r ? sync_serial_pkg::STAT_BF_MASK : 8'h00);
  assign rd_byte = hit_flags ? flags_r
                 : hit_enables ? enables_r
                 : hit_ctrl ? ctrl_r
                 : hit_buffer ? buffer_r
                 : hit_status ? status_w : 8'h00;
  assign flag_set = (serial_evt ? sync_serial_pkg::FLAG_SERIAL_MASK : 8'h00)
                  | (collide ? sync_serial_pkg::FLAG_COLL_MASK : 8'h00);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Sequencer and line drive
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_r <= sync_serial_pkg::ST_IDLE;
      qph_r <= 2'd0;
      bitcnt_r <= 4'd0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      qph_r <= qph_nxt;
      bitcnt_r <= bitcnt_nxt;
      scl_low_r <= scl_low_nxt;
      sda_low_r <= sda_low_nxt;
    end
  end

  // Hidden shift register: load, shift out, shift in
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      shift_r <= 8'h00;
    else if (launch_tx)
      shift_r <= buffer_r;
    else if (seq_end && tx_data)
      shift_r <= {shift_r[6:0], 1'b0};
    else if (sample && in_rx)
      shift_r <= {shift_r[6:0], sda_s};
  end

  // Transfer buffer and its flags; hardware set wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      buffer_r <= 8'h00;
      bf_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      tx_pend_r <= 1'b0;
    end
    else
    begin
      buffer_r <= rx_done ? shift_r : (buf_load ? pwdata[7:0] : buffer_r);
      bf_r <= buf_load | rx_done | (bf_r & ~(buf_rd | tx_byte_out));
      write_collision_flag_r <= write_collision_flag_set | (write_collision_flag_r & ~(wr & hit_status & ~pwdata[sync_serial_pkg::STAT_WRITE_COLLISION_FLAG_BIT]));
      tx_pend_r <= buf_load | (tx_pend_r & ~launch_tx);
    end
  end

  // Control, flag and enable registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ctrl_r <= sync_serial_pkg::ctrl_t'(sync_serial_pkg::CTRL_RST);
      flags_r <= sync_serial_pkg::FLAGS_RST;
      enables_r <= sync_serial_pkg::ENABLES_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      flags_r <= ((wr & hit_flags) ? pwdata[7:0] & sync_serial_pkg::IMPL_MASK : flags_r)
               | flag_set;
      enables_r <= (wr & hit_enables) ? pwdata[7:0] & sync_serial_pkg::IMPL_MASK
                 : enables_r;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_r <= {24'h00_0000, rd_byte};
  end

  // Open-drain pins: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_low_r;
  assign sda_oe = sda_low_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_CTRL_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (access && !pwrite && hit_ctrl) |-> prdata[7:0] == $past(ctrl_r))
    else $error("control read data wrong");

  AST_ACK_DONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (in_ack && seq_end) |=> (!ctrl_r.ack_sequence_go && idle && flags_r[7]))
    else $error("ack sequence did not finish cleanly");

  AST_ACK_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (in_ack && qph_r == 2'd1) |-> sda_oe == !ctrl_r.ack_value_bit)
    else $error("ack slot level wrong");

  AST_NO_SPOOL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ctrl_wr && !port_idle && wctrl.start_go && !ctrl_r.start_go) |=> !ctrl_r.start_go)
    else $error("start bit set while busy");

  AST_BUF_GUARD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (buf_wr && !port_idle && !rx_done) |=> buffer_r == $past(buffer_r))
    else $error("buffer written while busy");

  AST_RX_MODE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    in_rx |-> (ctrl_r.receive_go && !sda_oe))
    else $error("receive state without receive bit");

  AST_STOP_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (in_stop && seq_end) |=> (!ctrl_r.stop_go && !scl_oe && !sda_oe))
    else $error("stop did not release the bus");

  AST_RESTART_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (in_restart && qph_r == 2'd3) |-> (sda_oe && !scl_oe))
    else $error("restart data edge missing");

  AST_START_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (in_start && qph_r == 2'd2) |-> (sda_oe && !scl_oe))
    else $error("start data edge missing");

  AST_BF_RX: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rx_done |=> (bf_r && buffer_r == $past(shift_r)))
    else $error("received byte not loaded");

  AST_BF_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (buf_rd && !rx_done && !buf_load) |=> !bf_r)
    else $error("buffer read left full flag set");

  AST_ACK_STATUS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ack_sample |=> ctrl_r.ack_received_status == $past(sda_s))
    else $error("ack status not captured");

  AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !flags_r[sync_serial_pkg::UNIMPL_BIT] && !enables_r[sync_serial_pkg::UNIMPL_BIT])
    else $error("unimplemented bit set");

endmodule : sync_serial_master_control
`default_nettype wire

// ===== verif/i2c_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Serial slave: acks bytes, returns send_byte after a read address
// ----------------------------------------------------------------
module i2c_slave_model (
  input wire logic clk_sys,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_on,
  input wire logic [7:0] send_byte,
  output logic sda_pull
);
  logic scl_d = 1'h1;
  logic sda_d = 1'h1;
  logic first = 1'h0;
  logic rd = 1'h0;
  logic mack = 1'h1;
  logic [3:0] cnt = 4'hf;
  logic [7:0] sh = 8'h00;
  // Frame and bit tracking on the wire levels
  always @(posedge clk_sys)
  begin
    scl_d <= scl;
    sda_d <= sda;
    if (scl && scl_d && sda_d != sda)
    begin
      cnt <= 4'hf; // Start, restart or stop
      first <= !sda;
      rd <= 1'h0;
    end
    else if (scl && !scl_d && cnt < 4'h8)
      sh <= {sh[6:0], sda};
    else if (scl && !scl_d)
      mack <= sda; // Master ack slot level
    else if (!scl && scl_d)
    begin
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8)
      begin
        first <= 1'h0;
        rd <= first ? sh[0] : rd && !mack;
      end
    end
  end
  // Ack in slot nine of written bytes, read data MSB first
  assign sda_pull = (cnt == 4'h8) ? ack_on && !rd : rd && cnt < 4'h8 && !send_byte[3'h7 - cnt[2:0]];
endmodule : i2c_slave_model
`default_nettype wire

// ===== verif/sync_serial_master_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Register and link bench for the serial master control block
// ----------------------------------------------------------------
module sync_serial_master_control_bench;
  localparam int Q = 4;
  localparam logic [9:0] FL = sync_serial_pkg::ADDR_FLAGS;
  localparam logic [9:0] EN = sync_serial_pkg::ADDR_ENABLES;
  localparam logic [9:0] CT = sync_serial_pkg::ADDR_CTRL;
  localparam logic [9:0] BU = sync_serial_pkg::ADDR_BUFFER;
  localparam logic [9:0] ST = sync_serial_pkg::ADDR_STATUS;
  localparam logic [7:0] BUSY = sync_serial_pkg::STAT_BUSY_MASK;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_oe, sda_oe, pull, err_seen;
  logic ack_on = 1'h1;
  logic [8:0] seen = 9'h000;
  logic [31:0] q;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || pull);

  initial forever #50 clk_sys = !clk_sys;

  sync_serial_master_control #(.QUARTER_CYCLES(Q)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
  i2c_slave_model slave (.clk_sys(clk_sys), .scl(scl), .sda(sda), .ack_on(ack_on),
    .send_byte(8'h96), .sda_pull(pull));

  // Wire levels captured at each rising clock line
  always @(posedge scl) seen <= {seen[7:0], sda};

  task automatic chk(input string name, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, s);
    end
  endtask : chk

  // One transfer: setup, access held until pready
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1)
      @(posedge clk_sys);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rdc(input logic [9:0] a, input logic [31:0] e, input string n);
    apb(1'h0, a, 8'h00);
    chk(n, q, e);
  endtask : rdc

  // Poll until the masked bits clear, then expect and clear the done flag
  task automatic op(input logic [9:0] a, input logic [7:0] d, input logic [9:0] pa,
    input logic [7:0] m);
    if (a != 10'h000)
      apb(1'h1, a, d);
    apb(1'h0, pa, 8'h00);
    while ((q[7:0] & m) !== 8'h00)
      apb(1'h0, pa, 8'h00);
    rdc(FL, 32'h80, "done flag");
    apb(1'h1, FL, 8'h00);
  endtask : op

  task automatic final_report;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      final_report();
    end
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'h1;
    rdc(FL, 32'h02, "flags");
    rdc(EN, 32'h00, "enables");
    rdc(CT, 32'h00, "ctrl");
    apb(1'h1, EN, 8'hff);
    rdc(EN, 32'hef, "enables");
    apb(1'h1, FL, 8'h10);
    rdc(FL, 32'h00, "flags");
    apb(1'h1, CT, 8'ha0);
    rdc(CT, 32'ha0, "ctrl");
    apb(1'h0, 10'h3fc, 8'h00);
    chk("unmapped", {q[30:0], err_seen}, 32'h1);
    op(CT, 8'ha1, CT, 8'h01);
    apb(1'h1, BU, 8'ha1);
    apb(1'h1, BU, 8'h55);
    apb(1'h1, CT, 8'ha4);
    rdc(ST, 32'h85, "status");
    op(10'h000, 8'h00, ST, BUSY);
    rdc(CT, 32'ha0, "ctrl");
    chk("tx bits", seen, {8'ha1, 1'h0});
    chk("clock held", scl, 1'h0);
    apb(1'h1, ST, 8'h00);
    rdc(ST, 32'h00, "status");
    op(CT, 8'ha8, CT, 8'h08);
    rdc(ST, 32'h01, "buffer full");
    rdc(BU, 32'h96, "rx byte");
    rdc(ST, 32'h00, "buffer full");
    op(CT, 8'hb0, CT, 8'h10);
    chk("ack slot", seen[0], 1'h1);
    ack_on <= 1'h0;
    op(CT, 8'ha2, CT, 8'h02);
    op(BU, 8'ha0, ST, BUSY);
    rdc(CT, 32'he0, "ack status");
    op(CT, 8'ha4, CT, 8'h04);
    chk("lines", {scl, sda}, 2'h3);
    final_report();
  end
endmodule : sync_serial_master_control_bench
`default_nettype wire
